// [core/temp_action_mem.sv]
// Small register memory holding the paged response bytes.
`timescale 1ns/10ps
module temp_action_mem
  import temp_fault_pkg::*;
#(
  parameter int         WIDTH      = 8,
  parameter int         DEPTH      = 4,
  parameter int         ADDR_W     = 2,
  parameter logic [7:0] RESET_EVEN = RST_PS_OVERTEMP_ACTION,
  parameter logic [7:0] RESET_ODD  = RST_PS_UNDERTEMP_ACTION
) (
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire logic                   wr_en,
  input  wire logic [ADDR_W-1:0]      wr_addr,
  input  wire logic [WIDTH-1:0]       wr_data,
  input  wire logic [ADDR_W-1:0]      rd_addr,
  output logic      [WIDTH-1:0]       rd_data,
  output logic      [DEPTH*WIDTH-1:0] contents
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  // Every entry is also exposed flat, because the fault logic of all
  // channels must see its settings at once, not through one read port.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        contents[i*WIDTH +: WIDTH] <= (i % 2 == 0) ? RESET_EVEN : RESET_ODD;
      end
    end else if (wr_en) begin
      contents[int'(wr_addr)*WIDTH +: WIDTH] <= wr_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= contents[int'(rd_addr)*WIDTH +: WIDTH];
    end
  end

endmodule : temp_action_mem

// [core/temperature_fault_response.sv]
// Temperature fault response: command decode, status bits, alert and output control.
`timescale 1ns/10ps

// Behaviour
// - Internal overtemperature sets manufacturer summary and internal overtemperature status bits.
// - Internal overtemperature asserts alert unless its mask is set.
// - Writing internal response code 00 or 01 raises a CML fault.
// - Internal code 10 disables output at once, then follows retry field.
// - Internal code 11 holds output off while condition lasts, then re-enables.
// - Latched status clears on clear-faults, off-then-on run cycle, or power reset; the CML bit clears only on clear-faults or power reset.
// - Retry 000 means no restart; output stays off until fault cleared.
// - Writing internal retry field 001 to 111 raises a CML fault.
// - Internal delay field bits 2:0 are ignored.
// - Paged byte command 0x50 holds power stage overtemperature response, default 0xb8.
// - Paged byte command 0x54 holds power stage undertemperature response, default 0x00.
// - Power stage overtemperature sets temperature summary and overtemperature bits, alerts unless masked.
// - Power stage faults come from measurements; reaction may lag about 90 ms.
// - Each response command carries exactly one data byte.
// - Power stage code 00 keeps running but still sets status and alert.
// - Power stage retry 111 restarts repeatedly at the retry interval until stopped.
// - Power stage codes 01 and 11 are unsupported and raise CML on write.
module temperature_fault_response
  import temp_fault_pkg::*;
#(
  parameter int PAGES   = PAGES_DEFAULT,
  parameter int PAGE_W  = (PAGES > 1) ? $clog2(PAGES) : 1,
  parameter int RETRY_W = RETRY_COUNT_W
) (
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  wire pmbus_req_t         req,
  input  wire logic [PAGE_W-1:0]  page,
  output logic                    rsp_valid,
  output logic      [7:0]         rsp_data,
  input  wire logic               clear_faults,
  input  wire logic               internal_ot,
  input  wire logic [PAGES-1:0]   ps_ot,
  input  wire logic [PAGES-1:0]   ps_ut,
  input  wire logic               mask_internal_ot,
  input  wire logic [PAGES-1:0]   mask_ps_ot,
  input  wire logic [PAGES-1:0]   mask_ps_ut,
  input  wire logic [PAGES-1:0]   run_control_pin,
  input  wire logic [PAGES-1:0]   operation_on,
  input  wire logic [RETRY_W-1:0] retry_interval_setting,
  output logic      [PAGES-1:0]   output_enable,
  output logic                    status_word_mfr,
  output logic                    mfr_ot_fault,
  output logic      [PAGES-1:0]   status_byte_temp,
  output logic      [PAGES-1:0]   temp_ot_fault,
  output logic      [PAGES-1:0]   temp_ut_fault,
  output logic                    cml_fault,
  output logic                    alert_out,
  output logic                    alert_oe
);

  localparam int SLOTS  = 2 * PAGES;
  localparam int SLOT_W = PAGE_W + 1;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [7:0]             internal_action;
  logic                   mem_wr;
  logic                   int_wr;
  logic                   cml_set;
  logic                   page_ok;
  logic [SLOT_W-1:0]      wr_slot;
  logic [7:0]             mem_rd_data;
  logic [SLOTS*8-1:0]     mem_contents;
  logic                   rd_pending;
  logic [7:0]             rd_code;
  logic [PAGES-1:0]       cmd_on;
  logic [PAGES-1:0]       cmd_on_q;
  logic [PAGES-1:0]       on_rise;
  logic [PAGES-1:0]       chan_clear;
  logic [PAGES-1:0]       latch_trip;
  logic [PAGES-1:0]       retry_trip;
  logic                   int_trip;
  logic                   int_hold;
  chan_state_t            chan_state [PAGES];
  logic [RETRY_W-1:0]     retry_cnt  [PAGES];

  function automatic logic [7:0] slot_action(input logic [SLOTS*8-1:0] all, input int slot);
    slot_action = all[slot*8 +: 8];
  endfunction : slot_action

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  assign page_ok = (int'(page) < PAGES);
  assign wr_slot = (req.code == CMD_PS_UNDERTEMP_ACTION) ? {page, 1'b1} : {page, 1'b0};

  always_comb begin
    mem_wr  = 1'b0;
    int_wr  = 1'b0;
    cml_set = 1'b0;
    if (req.valid && req.write) begin
      if (req.byte_count != ONE_DATA_BYTE) begin
        cml_set = 1'b1;
      end else if (req.code == CMD_PS_OVERTEMP_ACTION || req.code == CMD_PS_UNDERTEMP_ACTION) begin
        if (ps_action_ok(req.data) && page_ok) begin
          mem_wr = 1'b1;
        end else begin
          cml_set = 1'b1;
        end
      end else if (req.code == CMD_INTERNAL_OT_ACTION) begin
        if (internal_action_ok(req.data)) begin
          int_wr = 1'b1;
        end else begin
          cml_set = 1'b1;
        end
      end else begin
        cml_set = 1'b1;
      end
    end else if (req.valid) begin
      if (req.code == CMD_PS_OVERTEMP_ACTION || req.code == CMD_PS_UNDERTEMP_ACTION) begin
        cml_set = !page_ok;
      end else if (req.code != CMD_INTERNAL_OT_ACTION) begin
        cml_set = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Response settings
  // ----------------------------------------------------------------------
  temp_action_mem #(
    .WIDTH      (8),
    .DEPTH      (SLOTS),
    .ADDR_W     (SLOT_W),
    .RESET_EVEN (RST_PS_OVERTEMP_ACTION),
    .RESET_ODD  (RST_PS_UNDERTEMP_ACTION)
  ) u_action_mem (
    .clock    (clock),
    .rst_n    (rst_n),
    .wr_en    (mem_wr),
    .wr_addr  (wr_slot),
    .wr_data  (req.data),
    .rd_addr  (wr_slot),
    .rd_data  (mem_rd_data),
    .contents (mem_contents)
  );

  // The delay bits are stored so that they read back, but nothing acts on them.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      internal_action <= RST_INTERNAL_OT_ACTION;
    end else if (int_wr) begin
      internal_action <= req.data;
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // Reads take two cycles: one for the memory register, one for the mux register.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rd_pending <= 1'b0;
      rd_code    <= '0;
    end else begin
      rd_pending <= req.valid && !req.write;
      rd_code    <= req.code;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_data  <= RST_READ_DATA;
    end else begin
      rsp_valid <= rd_pending;
      if (rd_code == CMD_INTERNAL_OT_ACTION) begin
        rsp_data <= internal_action;
      end else if (rd_code == CMD_PS_OVERTEMP_ACTION || rd_code == CMD_PS_UNDERTEMP_ACTION) begin
        rsp_data <= mem_rd_data;
      end else begin
        rsp_data <= RST_READ_DATA;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Fault decode per channel
  // ----------------------------------------------------------------------
  assign int_trip = internal_ot && (resp_field(internal_action) == RESP_SHUTDOWN);
  assign int_hold = internal_ot && (resp_field(internal_action) == RESP_WHILE_PRESENT);

  always_comb begin
    logic [7:0] ot_act;
    logic [7:0] ut_act;
    logic       ot_trip;
    logic       ut_trip;
    ot_act     = '0;
    ut_act     = '0;
    ot_trip    = 1'b0;
    ut_trip    = 1'b0;
    cmd_on     = '0;
    on_rise    = '0;
    chan_clear = '0;
    latch_trip = '0;
    retry_trip = '0;
    for (int c = 0; c < PAGES; c++) begin
      ot_act        = slot_action(mem_contents, 2 * c);
      ut_act        = slot_action(mem_contents, 2 * c + 1);
      ot_trip       = ps_ot[c] && (resp_field(ot_act) == RESP_SHUTDOWN);
      ut_trip       = ps_ut[c] && (resp_field(ut_act) == RESP_SHUTDOWN);
      cmd_on[c]     = run_control_pin[c] && operation_on[c];
      on_rise[c]    = cmd_on[c] && !cmd_on_q[c];
      chan_clear[c] = clear_faults || on_rise[c];
      latch_trip[c] = int_trip || (ot_trip && retry_field(ot_act) != RETRY_FOREVER)
                      || (ut_trip && retry_field(ut_act) != RETRY_FOREVER);
      retry_trip[c] = (ot_trip && retry_field(ot_act) == RETRY_FOREVER)
                      || (ut_trip && retry_field(ut_act) == RETRY_FOREVER);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cmd_on_q <= '0;
    end else begin
      cmd_on_q <= cmd_on;
    end
  end

  // ----------------------------------------------------------------------
  // Channel state and output control
  // ----------------------------------------------------------------------
  // A clear while the fault is still present simply re-trips on the next cycle.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int c = 0; c < PAGES; c++) begin
        chan_state[c] <= CH_RUN;
        retry_cnt[c]  <= '0;
      end
    end else begin
      for (int c = 0; c < PAGES; c++) begin
        if (chan_clear[c]) begin
          chan_state[c] <= CH_RUN;
        end else begin
          case (chan_state[c])
            CH_RUN: begin
              if (cmd_on[c] && latch_trip[c]) begin
                chan_state[c] <= CH_LATCHED_OFF;
              end else if (cmd_on[c] && retry_trip[c]) begin
                chan_state[c] <= CH_RETRY_WAIT;
                retry_cnt[c]  <= retry_interval_setting;
              end
            end
            CH_LATCHED_OFF: begin
              chan_state[c] <= CH_LATCHED_OFF;
            end
            CH_RETRY_WAIT: begin
              if (latch_trip[c]) begin
                chan_state[c] <= CH_LATCHED_OFF;
              end else if (!cmd_on[c] || retry_cnt[c] == '0) begin
                chan_state[c] <= CH_RUN;
              end else begin
                retry_cnt[c] <= retry_cnt[c] - 1'b1;
              end
            end
            default: begin
              chan_state[c] <= CH_RUN;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      output_enable <= '0;
    end else begin
      for (int c = 0; c < PAGES; c++) begin
        output_enable[c] <= cmd_on[c] && (chan_state[c] == CH_RUN) && !chan_clear[c]
                            && !latch_trip[c] && !retry_trip[c] && !int_hold;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Status bits and alert
  // ----------------------------------------------------------------------
  // Every sticky bit lets a new event win over a clear in the same cycle.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      status_word_mfr <= 1'b0;
      mfr_ot_fault    <= 1'b0;
    end else begin
      status_word_mfr <= (status_word_mfr && !(|chan_clear)) || internal_ot;
      mfr_ot_fault    <= (mfr_ot_fault && !(|chan_clear)) || internal_ot;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      status_byte_temp <= '0;
      temp_ot_fault    <= '0;
      temp_ut_fault    <= '0;
    end else begin
      status_byte_temp <= (status_byte_temp & ~chan_clear) | ps_ot | ps_ut;
      temp_ot_fault    <= (temp_ot_fault & ~chan_clear) | ps_ot;
      temp_ut_fault    <= (temp_ut_fault & ~chan_clear) | ps_ut;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cml_fault <= 1'b0;
    end else begin
      cml_fault <= (cml_fault && !clear_faults) || cml_set;
    end
  end

  // The alert is an open-drain low: the pin is pulled down whenever enabled.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      alert_out <= 1'b0;
      alert_oe  <= 1'b0;
    end else begin
      alert_out <= 1'b0;
      alert_oe  <= (mfr_ot_fault && !mask_internal_ot)
                   || (|(temp_ot_fault & ~mask_ps_ot))
                   || (|(temp_ut_fault & ~mask_ps_ut))
                   || cml_fault;
    end
  end

endmodule : temperature_fault_response

// [include/temp_fault_pkg.sv]
// Constants, types and helpers shared by the temperature fault response design.
package temp_fault_pkg;

  // ----------------------------------------------------------------------
  // Command codes and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_PS_OVERTEMP_ACTION  = 8'h50;
  localparam logic [7:0] CMD_PS_UNDERTEMP_ACTION = 8'h54;
  localparam logic [7:0] CMD_INTERNAL_OT_ACTION  = 8'hd6;
  localparam logic [7:0] RST_PS_OVERTEMP_ACTION  = 8'hb8;
  localparam logic [7:0] RST_PS_UNDERTEMP_ACTION = 8'h00;
  localparam logic [7:0] RST_INTERNAL_OT_ACTION  = 8'hc0;
  localparam logic [7:0] RST_READ_DATA           = 8'h00;

  // ----------------------------------------------------------------------
  // Field layout of a response byte
  // ----------------------------------------------------------------------
  localparam int RESP_MSB  = 7;
  localparam int RESP_LSB  = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DELAY_MSB = 2;
  localparam int DELAY_LSB = 0;

  localparam logic [1:0] RESP_CONTINUE      = 2'b00;
  localparam logic [1:0] RESP_UNSUPPORTED   = 2'b01;
  localparam logic [1:0] RESP_SHUTDOWN      = 2'b10;
  localparam logic [1:0] RESP_WHILE_PRESENT = 2'b11;
  localparam logic [2:0] RETRY_NONE         = 3'b000;
  localparam logic [2:0] RETRY_FOREVER      = 3'b111;
  localparam logic [1:0] ONE_DATA_BYTE      = 2'b01;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLOCK_MHZ        = 200;
  localparam int ADC_LAG_MS       = 90;
  localparam int ADC_LAG_CYCLES   = ADC_LAG_MS * 1000 * CLOCK_MHZ;
  localparam int RETRY_COUNT_W    = 16;
  localparam int PAGES_DEFAULT    = 2;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    CH_RUN         = 2'b00,
    CH_LATCHED_OFF = 2'b01,
    CH_RETRY_WAIT  = 2'b10
  } chan_state_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] code;
    logic [7:0] data;
    logic [1:0] byte_count;
  } pmbus_req_t;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [1:0] resp_field(input logic [7:0] b);
    resp_field = b[RESP_MSB:RESP_LSB];
  endfunction : resp_field

  function automatic logic [2:0] retry_field(input logic [7:0] b);
    retry_field = b[RETRY_MSB:RETRY_LSB];
  endfunction : retry_field

  function automatic logic ps_action_ok(input logic [7:0] b);
    ps_action_ok = (resp_field(b) == RESP_CONTINUE) || (resp_field(b) == RESP_SHUTDOWN);
  endfunction : ps_action_ok

  function automatic logic internal_action_ok(input logic [7:0] b);
    internal_action_ok = (resp_field(b) != RESP_CONTINUE) && (resp_field(b) != RESP_UNSUPPORTED)
                         && (retry_field(b) == RETRY_NONE);
  endfunction : internal_action_ok

endpackage : temp_fault_pkg

// [tb/pmbus_host_model.sv]
// Host controller model: single-byte commands and the alert line.
`timescale 1ns/10ps
module pmbus_host_model
  import temp_fault_pkg::*;
(
  input  wire logic       clock,
  output pmbus_req_t      req,
  output logic            page,
  input  wire logic       rsp_valid,
  input  wire logic [7:0] rsp_data,
  input  wire logic       alert_oe,
  output wire logic       alert_n
);
  // --------------------------------
  // Command issue
  // --------------------------------
  // The alert pin has a pull-up, so it reads high whenever the device lets go.
  assign alert_n = alert_oe ? 1'b0 : 1'b1;

  initial begin
    req = '0;
    page = 1'b0;
  end

  // Released fields carry inverted values so nothing can lean on stale ones.
  task automatic send(input logic w, input logic [7:0] c, input logic [7:0] d, input logic [1:0] bc,
                      input logic pg);
    @(posedge clock);
    req <= '{1'b1, w, c, d, bc};
    page <= pg;
    @(posedge clock);
    req <= '{1'b0, ~w, ~c, ~d, ~bc};
  endtask : send

  task automatic wr(input logic [7:0] c, input logic [7:0] d, input logic pg);
    send(1'b1, c, d, ONE_DATA_BYTE, pg);
  endtask : wr

  task automatic rd(input logic [7:0] c, input logic pg, output logic v, output logic [7:0] d);
    send(1'b0, c, 8'h00, ONE_DATA_BYTE, pg);
    @(posedge clock);
    #1;
    v = rsp_valid;
    d = rsp_data;
  endtask : rd
endmodule : pmbus_host_model

// [tb/tb_temperature_fault_response.sv]
// Self-checking bench for the temperature fault response block.
`timescale 1ns/10ps
module tb_temperature_fault_response
  import temp_fault_pkg::*;
;
  // --------------------------------
  // Signals and instances
  // --------------------------------
  logic        clock = 1'b0, rst_n = 1'b0, clear_faults = 1'b0, internal_ot = 1'b0, mask_internal_ot = 1'b0;
  logic [1:0]  ps_ot = '0, ps_ut = '0, mask_ps_ot = '0, mask_ps_ut = '0, run_control_pin = '0, operation_on = '0;
  logic [15:0] retry_interval_setting = 16'h0004;
  logic [1:0]  output_enable, status_byte_temp, temp_ot_fault, temp_ut_fault;
  logic        page, rsp_valid, status_word_mfr, mfr_ot_fault, cml_fault, alert_out, alert_oe, alert_n;
  logic [7:0]  rsp_data;
  logic [7:0]  slot [2][2];
  pmbus_req_t  req;
  int          mismatches = 0, n_compared = 0;

  always #2.5 clock = ~clock;

  temperature_fault_response #(.PAGES(2), .PAGE_W(1), .RETRY_W(16)) dut_u (.*);

  pmbus_host_model host_u (.clock(clock), .req(req), .page(page), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
                           .alert_oe(alert_oe), .alert_n(alert_n));

  // --------------------------------
  // Helpers
  // --------------------------------
  function automatic logic ps_ok(input logic [7:0] d);
    ps_ok = !d[6];
  endfunction : ps_ok

  function automatic logic int_ok(input logic [7:0] d);
    int_ok = d[7] && d[5:3] == 3'b000;
  endfunction : int_ok

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  task automatic clr();
    @(posedge clock);
    clear_faults <= 1'b1;
    @(posedge clock);
    clear_faults <= 1'b0;
    tick(2);
    #1;
  endtask : clr

  task automatic rdchk(input logic [7:0] c, input logic p, input logic [7:0] e);
    logic       v;
    logic [7:0] d;
    host_u.rd(c, p, v, d);
    chk(v, 1'b1);
    chk(d, e);
  endtask : rdchk

  task automatic summarize();
    $display("compared=%0d mismatches=%0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  // Generous limit; the sequence needs well under a thousand cycles.
  initial begin
    #100000;
    mismatches++;
    summarize();
  end

  // --------------------------------
  // Scenarios
  // --------------------------------
  initial begin
    logic [7:0] d, c, ie;
    int         k, p;
    void'($urandom(32'hb768));
    tick(10);
    rst_n <= 1'b1;
    run_control_pin <= 2'b11;
    operation_on <= 2'b11;
    tick(3);
    ie = RST_INTERNAL_OT_ACTION;
    for (int q = 0; q < 2; q++) begin
      slot[0][q] = 8'hb8;
      slot[1][q] = 8'h00;
      rdchk(CMD_PS_OVERTEMP_ACTION, q[0], 8'hb8);
      rdchk(CMD_PS_UNDERTEMP_ACTION, q[0], 8'h00);
    end
    rdchk(CMD_INTERNAL_OT_ACTION, 1'b0, ie);
    for (int i = 0; i < 16; i++) begin
      d = {i[1:0], 6'($urandom)};
      k = $urandom % 2;
      p = $urandom % 2;
      c = (k == 1) ? CMD_PS_UNDERTEMP_ACTION : CMD_PS_OVERTEMP_ACTION;
      host_u.wr(c, d, p[0]);
      if (ps_ok(d)) slot[k][p] = d;
      tick(1);
      #1;
      chk(cml_fault, !ps_ok(d));
      rdchk(c, p[0], slot[k][p]);
      rdchk(c, ~p[0], slot[k][1-p]);
      clr();
    end
    for (int b = 0; b < 4; b += 2) begin
      host_u.send(1'b1, CMD_PS_OVERTEMP_ACTION, 8'h80, 2'(b), 1'b0);
      tick(1);
      #1;
      chk(cml_fault, 1'b1);
      rdchk(CMD_PS_OVERTEMP_ACTION, 1'b0, slot[0][0]);
      clr();
    end
    for (int i = 0; i < 8; i++) begin
      d = {i[1:0], i[2] ? (3'($urandom) | 3'b001) : 3'b000, 3'($urandom)};
      host_u.wr(CMD_INTERNAL_OT_ACTION, d, 1'b0);
      if (int_ok(d)) ie = d;
      tick(1);
      #1;
      chk(cml_fault, !int_ok(d));
      rdchk(CMD_INTERNAL_OT_ACTION, 1'b0, ie);
      clr();
    end
    host_u.wr(CMD_INTERNAL_OT_ACTION, 8'h87, 1'b0);
    @(posedge clock) internal_ot <= 1'b1;
    @(posedge clock) internal_ot <= 1'b0;
    tick(2);
    #1;
    chk({status_word_mfr, mfr_ot_fault}, 2'b11);
    chk(output_enable, 2'b00);
    chk(alert_n, 1'b0);
    tick(20);
    #1;
    chk(output_enable, 2'b00);
    chk(mfr_ot_fault, 1'b1);
    clr();
    chk({status_word_mfr, mfr_ot_fault, alert_n}, 3'b001);
    chk(output_enable, 2'b11);
    host_u.wr(CMD_INTERNAL_OT_ACTION, 8'hc0, 1'b0);
    @(posedge clock) mask_internal_ot <= 1'b1;
    internal_ot <= 1'b1;
    tick(3);
    #1;
    chk(output_enable, 2'b00);
    chk(alert_n, 1'b1);
    @(posedge clock) internal_ot <= 1'b0;
    tick(2);
    #1;
    chk(output_enable, 2'b11);
    clr();
    @(posedge clock) mask_internal_ot <= 1'b0;
    host_u.wr(CMD_PS_OVERTEMP_ACTION, 8'hb8, 1'b0);
    @(posedge clock) ps_ot <= 2'b01;
    @(posedge clock) ps_ot <= 2'b00;
    tick(1);
    #1;
    chk({temp_ot_fault, status_byte_temp}, 4'b0101);
    chk(output_enable, 2'b10);
    tick(12);
    #1;
    chk(output_enable, 2'b11);
    chk(alert_n, 1'b0);
    clr();
    host_u.wr(CMD_PS_UNDERTEMP_ACTION, 8'h00, 1'b1);
    @(posedge clock) ps_ut <= 2'b10;
    @(posedge clock) ps_ut <= 2'b00;
    tick(3);
    #1;
    chk(temp_ut_fault, 2'b10);
    chk({output_enable, alert_n, alert_out}, 4'b1100);
    @(posedge clock) run_control_pin <= 2'b01;
    tick(2);
    @(posedge clock) run_control_pin <= 2'b11;
    tick(3);
    #1;
    chk({temp_ut_fault, status_byte_temp}, 4'b0000);
    summarize();
  end
endmodule : tb_temperature_fault_response

// [tb/temperature_fault_response_sva.sv]
// Port assertions for the temperature fault response block.
`timescale 1ns/10ps
module temperature_fault_response_sva
  import temp_fault_pkg::*;
#(
  parameter int PAGES   = PAGES_DEFAULT,
  parameter int PAGE_W  = 1,
  parameter int RETRY_W = RETRY_COUNT_W
) (
  input wire logic               clock,
  input wire logic               rst_n,
  input wire pmbus_req_t         req,
  input wire logic [PAGE_W-1:0]  page,
  input wire logic               rsp_valid,
  input wire logic [7:0]         rsp_data,
  input wire logic               clear_faults,
  input wire logic               internal_ot,
  input wire logic [PAGES-1:0]   ps_ot,
  input wire logic [PAGES-1:0]   ps_ut,
  input wire logic               mask_internal_ot,
  input wire logic [PAGES-1:0]   mask_ps_ot,
  input wire logic [PAGES-1:0]   mask_ps_ut,
  input wire logic [PAGES-1:0]   run_control_pin,
  input wire logic [PAGES-1:0]   operation_on,
  input wire logic [RETRY_W-1:0] retry_interval_setting,
  input wire logic [PAGES-1:0]   output_enable,
  input wire logic               status_word_mfr,
  input wire logic               mfr_ot_fault,
  input wire logic [PAGES-1:0]   status_byte_temp,
  input wire logic [PAGES-1:0]   temp_ot_fault,
  input wire logic [PAGES-1:0]   temp_ut_fault,
  input wire logic               cml_fault,
  input wire logic               alert_out,
  input wire logic               alert_oe
);
  // --------------------------------
  // Properties
  // --------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  wire logic wr_any = req.valid && req.write;
  wire logic on0    = run_control_pin[0] && operation_on[0];

  sequence s_read;
    req.valid && !req.write;
  endsequence
  sequence s_int_alerting;
    mfr_ot_fault && !mask_internal_ot ##1 mfr_ot_fault && !mask_internal_ot;
  endsequence

  AST_READ_ANSWER: assert property (s_read |-> ##2 rsp_valid)
    else $error("read answer missing two cycles after request");
  AST_NO_STRAY_ANSWER: assert property (!$past(req.valid && !req.write, 2) |-> !rsp_valid)
    else $error("read answer without a read request");
  AST_CML_BYTE_COUNT: assert property (wr_any && req.byte_count != ONE_DATA_BYTE |=> cml_fault)
    else $error("wrong byte count did not raise cml");
  AST_CML_INT_CODE: assert property (wr_any && req.code == CMD_INTERNAL_OT_ACTION && !req.data[7] |=> cml_fault)
    else $error("internal code 00 or 01 did not raise cml");
  AST_CML_INT_RETRY: assert property (wr_any && req.code == CMD_INTERNAL_OT_ACTION && req.data[5:3] != 3'b000
                                      |=> cml_fault)
    else $error("internal nonzero retry did not raise cml");
  AST_CML_PS_CODE: assert property (wr_any && req.data[6] && (req.code == CMD_PS_OVERTEMP_ACTION
                                    || req.code == CMD_PS_UNDERTEMP_ACTION) |=> cml_fault)
    else $error("power stage code 01 or 11 did not raise cml");
  AST_INT_STATUS: assert property (internal_ot |=> status_word_mfr && mfr_ot_fault)
    else $error("internal overtemperature status not set");
  AST_INT_ALERT: assert property (s_int_alerting |-> alert_oe)
    else $error("unmasked internal fault without alert");
  AST_INT_OUTPUT_OFF: assert property (internal_ot |=> output_enable == '0)
    else $error("output left on during internal overtemperature");
  AST_PS_STATUS: assert property (ps_ot[0] |=> temp_ot_fault[0] && status_byte_temp[0])
    else $error("power stage overtemperature status not set");
  AST_STICKY_HOLD: assert property ($fell(temp_ot_fault[0]) |-> $past(clear_faults) || $past(clear_faults, 2)
                                    || ($past(on0) && !$past(on0, 2)) || ($past(on0, 2) && !$past(on0, 3)))
    else $error("overtemperature status cleared without a clearing event");
endmodule : temperature_fault_response_sva

bind temperature_fault_response temperature_fault_response_sva #(
  .PAGES(PAGES), .PAGE_W(PAGE_W), .RETRY_W(RETRY_W)
) sva_u (.*);
